// >>> hdl/backlight_fade.sv
/*
 * backlight fade-in and daylight maximum current register bank.
 * assumes a host-side serial slave turns bus transfers into reg_wr/reg_addr/reg_wdata
 * strobes on clk_sys; read data is returned registered one cycle later.
 */
`timescale 1ns/1ps
`include "fade_cfg.svh"
module backlight_fade #(
   parameter int STEP_W      = 24,
   parameter int UNIT_CYCLES = `UNIT_STEP_CYCLES,
   parameter int FAST_CYCLES = `FAST_STEP_CYCLES
)(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        backlight_on,
   input  wire logic        law_square,
   output logic      [6:0]  dac_code,
   output logic      [15:0] current_ua,
   output logic             ramp_busy
);
   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   logic       rst_meta_reg;
   logic       rst_sync_n;
   logic [1:0] on_sync_reg;
   logic [1:0] law_sync_reg;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // pins cross in through two flops; only the second stage is read
   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         on_sync_reg  <= 2'b00;
         law_sync_reg <= 2'b00;
      end
      else
      begin
         on_sync_reg  <= {on_sync_reg[0], backlight_on};
         law_sync_reg <= {law_sync_reg[0], law_square};
      end
   end
   wire on_now = on_sync_reg[1];
   wire fade_pkg::current_law_t law = fade_pkg::current_law_t'(law_sync_reg[1]);

   // ----------------------------------------
   // register file
   // ----------------------------------------
   logic [6:0] max_code_reg;
   logic [3:0] fade_in_reg;
   wire        hit_max  = (reg_addr == `MAX_CURRENT_OFFSET);
   wire        hit_fade = (reg_addr == `FADE_CTRL_OFFSET);
   wire [7:0]  rd_mux   = hit_max  ? {1'b0, max_code_reg} :
                          hit_fade ? {4'h0, fade_in_reg}  :
                          8'h00;

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         max_code_reg <= 7'(`MAX_CURRENT_RESET);
         fade_in_reg  <= 4'(`FADE_CTRL_RESET);
         reg_rdata    <= 8'h00;
      end
      else
      begin
         if (reg_wr && hit_max)
            max_code_reg <= reg_wdata[`CODE_MSB:0]; // bit 7 dropped
         if (reg_wr && hit_fade)
            fade_in_reg <= reg_wdata[`FADE_CODE_MSB:0];
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------
   // step interval selection
   // ----------------------------------------
   // full-scale fade time in 0.1 s units; steps widen from 0.3 s to 0.5 s above the knee,
   // so a plain code*0.3 s product would fall a whole second short at the top code
   function automatic logic [5:0] fade_tenths(input logic [3:0] code);
      if (code <= 4'(`FADE_KNEE_CODE))
         fade_tenths = 6'(`FADE_LOW_TENTHS * code);
      else
         fade_tenths = 6'(`FADE_KNEE_CODE * `FADE_LOW_TENTHS
                          + `FADE_HIGH_TENTHS * (code - 4'(`FADE_KNEE_CODE)));
   endfunction : fade_tenths

   // per-step period scales with full-scale time, so a 0..127 ramp takes that time;
   // a shorter ramp has fewer steps and finishes in proportion
   wire [5:0]        fade_units = fade_tenths(fade_in_reg);
   wire [STEP_W-1:0] period = (fade_in_reg == 4'h0)
                              ? STEP_W'(FAST_CYCLES)
                              : STEP_W'(UNIT_CYCLES) * STEP_W'(fade_units);

   // ----------------------------------------
   // ramp state machine
   // ----------------------------------------
   wire [6:0] target = on_now ? max_code_reg : 7'h00;
   fade_pkg::ramp_state_t state_reg;
   fade_pkg::ramp_state_t state_next;
   logic [6:0] code_reg;
   logic       tick;
   wire        run = (state_reg != fade_pkg::RAMP_IDLE);

   step_timer #(.W(STEP_W)) u_timer (
      .clk_sys    (clk_sys),
      .rst_sync_n (rst_sync_n),
      .run        (run),
      .period     (period),
      .tick       (tick)
   );

   // direction follows target, so a mid-ramp change turns from present value
   always_comb
   begin
      case (state_reg)
         fade_pkg::RAMP_IDLE,
         fade_pkg::RAMP_UP,
         fade_pkg::RAMP_DOWN:
            state_next = (code_reg < target) ? fade_pkg::RAMP_UP :
                         (code_reg > target) ? fade_pkg::RAMP_DOWN :
                         fade_pkg::RAMP_IDLE;
         default:
            state_next = fade_pkg::RAMP_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state_reg <= fade_pkg::RAMP_IDLE;
         code_reg  <= 7'h00;
      end
      else
      begin
         state_reg <= state_next;
         if (tick && state_reg == fade_pkg::RAMP_UP && code_reg < target)
            code_reg <= code_reg + 7'd1;
         else if (tick && state_reg == fade_pkg::RAMP_DOWN && code_reg > target)
            code_reg <= code_reg - 7'd1;
      end
   end

   // ----------------------------------------
   // code to current, in microamps
   // ----------------------------------------
   // linear: code*30000/127; square: code^2*30000/16129; both exact at 0 and 127
   wire [31:0] lin_ua = (32'(code_reg) * 32'd30000) / 32'd127;
   wire [31:0] sq_ua  = (32'(code_reg) * 32'(code_reg) * 32'd30000) / 32'd16129;
   wire [15:0] ua_mux = (law == fade_pkg::LAW_SQUARE) ? sq_ua[15:0] : lin_ua[15:0];

   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         dac_code   <= 7'h00;
         current_ua <= 16'h0000;
         ramp_busy  <= 1'b0;
      end
      else
      begin
         dac_code   <= code_reg;
         current_ua <= ua_mux;
         ramp_busy  <= run;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      $past(reg_rd) && $past(hit_max) |-> reg_rdata == {1'b0, $past(max_code_reg)})
      else $error("maximum register read back wrong or reserved bit set");
   a_idle_rdata: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not cleared between reads");
   a_max_write: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      reg_wr && hit_max |=> max_code_reg == $past(reg_wdata[6:0]))
      else $error("maximum code not stored");
   a_step_one: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      code_reg != $past(code_reg) |-> $past(tick))
      else $error("code moved without a step tick");
   a_up_dir: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      tick && state_reg == fade_pkg::RAMP_UP && code_reg < target
      |=> code_reg == $past(code_reg) + 7'd1)
      else $error("ramp up did not advance by one");
   a_down_dir: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      tick && state_reg == fade_pkg::RAMP_DOWN && code_reg > target
      |=> code_reg == $past(code_reg) - 7'd1)
      else $error("ramp down did not retreat by one");
   a_fast_period: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      fade_in_reg == 4'h0 |-> period == STEP_W'(FAST_CYCLES))
      else $error("disabled fade not using fast step");
   a_scaled_period: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      fade_in_reg == 4'h2 |-> period == STEP_W'(UNIT_CYCLES * 6))
      else $error("fade code two not six units of step");
   a_slowest_period: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      fade_in_reg == 4'hF |-> period == STEP_W'(UNIT_CYCLES * 55))
      else $error("fade code fifteen not fifty-five units of step");
   a_full_scale: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      dac_code == 7'h7F |=> current_ua == 16'd30000 || $past(code_reg) != 7'h7F)
      else $error("full code not 30 mA");
   a_zero_current: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
      code_reg == 7'h00 |=> current_ua == 16'h0000)
      else $error("zero code not 0 mA");
endmodule : backlight_fade

// >>> hdl/fade_cfg.svh
/*
 * constants for the backlight fade-in and daylight maximum current block.
 * assumes it is included by bare name from the backlight_fade module only.
 */
`ifndef FADE_CFG_SVH
`define FADE_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define MAX_CURRENT_OFFSET   8'h09
`define FADE_CTRL_OFFSET     8'h0A
`define CODE_MSB             6
`define FADE_CODE_MSB        3
`define MAX_CURRENT_RESET    8'h00
`define FADE_CTRL_RESET      8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ               20000000
`define FULL_SCALE_STEPS     127
`define FADE_UNIT_MS         100
`define FAST_RAMP_MS         100
// full-scale time in 0.1 s units: 0.3 s per code up to the knee, 0.5 s above it
`define FADE_KNEE_CODE       10
`define FADE_LOW_TENTHS      3
`define FADE_HIGH_TENTHS     5
// cycles per code step for one 0.1 s unit; duration n*0.1 s uses n times this
`define UNIT_STEP_CYCLES     ((`CLK_HZ / 1000) * `FADE_UNIT_MS / `FULL_SCALE_STEPS)
// fast ramp rounds down so it stays within 100 ms
`define FAST_STEP_CYCLES     ((`CLK_HZ / 1000) * `FAST_RAMP_MS / `FULL_SCALE_STEPS)

`endif

// >>> hdl/fade_pkg.sv
/*
 * types for the fade block.
 * assumes fade_cfg.svh is on the include path.
 */
package fade_pkg;
   typedef enum logic [1:0]
   {
      RAMP_IDLE = 2'b00,
      RAMP_UP   = 2'b01,
      RAMP_DOWN = 2'b11
   } ramp_state_t;

   typedef enum logic { LAW_LINEAR = 1'b0, LAW_SQUARE = 1'b1 } current_law_t;
endpackage : fade_pkg

// >>> hdl/step_timer.sv
/*
 * step interval counter: pulses tick every period cycles while running.
 * assumes period is held stable by the caller during a ramp.
 */
`timescale 1ns/1ps
module step_timer #(
   parameter int W = 24
)(
   input  wire logic         clk_sys,
   input  wire logic         rst_sync_n,
   input  wire logic         run,
   input  wire logic [W-1:0] period,
   output logic              tick
);
   logic [W-1:0] count_reg;
   wire          expired = (count_reg >= period - W'(1));

   // ----------------------------------------
   // interval counter
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         count_reg <= '0;
         tick      <= 1'b0;
      end
      else
      begin
         count_reg <= (!run || expired) ? '0 : count_reg + W'(1);
         tick      <= run && expired;
      end
   end
endmodule : step_timer

// >>> sim/host_model.sv
/*
 * host model: issues register writes and reads as one-cycle strobes.
 * assumes the bench calls its tasks only after reset is released.
 */
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   // idle bus at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // released data is inverted so a stale value is never read as valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr

   // read data is taken one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
endmodule : host_model

// >>> sim/testbench.sv
/*
 * testbench for the fade block, with short step periods (2 cycles per 0.1 s unit).
 * assumes host_model drives the register strobes.
 */
`timescale 1ns/1ps
module testbench;
   logic        clk_sys, rst_n, reg_wr, reg_rd, backlight_on, law_square, ramp_busy;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;
   logic [6:0]  dac_code;
   logic [15:0] current_ua;
   int          miscompares = 0;
   int          n_tests = 0;

   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   backlight_fade #(.UNIT_CYCLES(2), .FAST_CYCLES(2)) backlight_fade_i (.clk_sys(clk_sys),
      .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .backlight_on(backlight_on),
      .law_square(law_square), .dac_code(dac_code), .current_ua(current_ua),
      .ramp_busy(ramp_busy));

   host_model host_model_i (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic test_done;
      if (miscompares == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   // switch and time the ramp; busy must stand halfway through
   task automatic ramp(input logic on, input logic [6:0] code, input int cyc);
      int n;
      n = 0;
      @(posedge clk_sys);
      backlight_on <= on;
      while (dac_code !== code && n < 3000)
      begin
         @(posedge clk_sys);
         n++;
         if (n == cyc / 2) check({15'h0000, ramp_busy}, 16'h0001);
      end
      check({15'h0000, n > cyc - 8 && n < cyc + 8}, 16'h0001);
   endtask : ramp

   // maximum register reset value, reserved bit and unmapped address
   task automatic t_regs;
      host_model_i.rd(8'h09, v);
      check({8'h00, v}, 16'h0000);
      host_model_i.wr(8'h09, 8'hFF);
      host_model_i.wr(8'h0B, 8'h55);
      host_model_i.rd(8'h09, v);
      check({8'h00, v}, 16'h007F);
      host_model_i.rd(8'h0B, v);
      check({8'h00, v}, 16'h0000);
      host_model_i.wr(8'h0A, 8'hF3);
      host_model_i.rd(8'h0A, v);
      check({8'h00, v}, 16'h0003);
   endtask : t_regs

   // full-scale linear ramp at 0.3 s, then back down
   task automatic t_linear;
      host_model_i.wr(8'h0A, 8'h01);
      ramp(1'b1, 7'h7F, 762);
      check(current_ua, 16'h7530);
      ramp(1'b0, 7'h00, 762);
      check(current_ua, 16'h0000);
   endtask : t_linear

   // partial square-law ramp at the slowest code
   task automatic t_square;
      law_square <= 1'b1;
      host_model_i.wr(8'h0A, 8'h0F);
      host_model_i.wr(8'h09, 8'h10);
      ramp(1'b1, 7'h10, 1760);
      check(current_ua, 16'h01DC);
      ramp(1'b0, 7'h00, 1760);
   endtask : t_square

   // fading disabled still ramps, at the fast step
   task automatic t_fast;
      law_square <= 1'b0;
      host_model_i.wr(8'h0A, 8'h00);
      host_model_i.wr(8'h09, 8'h7F);
      ramp(1'b1, 7'h7F, 254);
      check(current_ua, 16'h7530);
   endtask : t_fast

   initial
   begin
      rst_n = 1'b0;
      backlight_on = 1'b0;
      law_square = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_regs();
      t_linear();
      t_square();
      t_fast();
      test_done();
   end

   // watchdog: the tests need about 5500 cycles
   initial
   begin
      #(12000 * 50);
      miscompares++;
      test_done();
   end
endmodule : testbench
